// File: verilog/qadc_defs.vh
`ifndef QADC_DEFS_VH
`define QADC_DEFS_VH

// converter and bus geometry
`define QADC_CH_COUNT        4
`define QADC_LANE_W          8
`define QADC_BUS_W           32
`define QADC_CONV_W          12
`define QADC_MUX_W           8

// timing, all in nanoseconds
`define QADC_CLK_PERIOD_NS   8
`define QADC_CONV_LOW_NS     50
`define QADC_READY_DELAY_NS  480
`define QADC_CONV_MAX_NS     1000

// mux address reset value
`define QADC_MUX_RESET       8'h00

`endif

// File: verilog/qadc_lane.v
`timescale 1ns/1ns
`default_nettype none
`include "qadc_defs.vh"

// one converter channel: end-of-conversion capture and lane drive
module qadc_lane
#(
    parameter CONV_W = `QADC_CONV_W,
    parameter LANE_W = `QADC_LANE_W
)
(
    // clock and reset
    input  wire              clk,
    input  wire              reset_n,
    // converter side
    input  wire [CONV_W-1:0] conv_data,
    input  wire              conv_status,
    // bus side
    input  wire              lane_read_strobe,
    output reg  [LANE_W-1:0] lane_data_q,
    output reg               lane_oe_q,
    output reg               busy_q
);

    reg status_q;
    wire eoc;

    // capture on the falling status, i.e. rising inverted status
    assign eoc = status_q & ~conv_status;

    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            status_q    <= 1'b0;
            lane_data_q <= {LANE_W{1'b0}};
            lane_oe_q   <= 1'b0;
            busy_q      <= 1'b0;
        end
        else
        begin
            status_q <= conv_status;
            busy_q   <= conv_status;
            // only the top bits, stored true-high offset binary
            if (eoc)
                lane_data_q <= conv_data[CONV_W-1 -: LANE_W];
            lane_oe_q <= lane_read_strobe;
        end
    end

endmodule // qadc_lane

`default_nettype wire

// File: verilog/qadc_port_ctrl.v
`timescale 1ns/1ns
`default_nettype none
`include "qadc_defs.vh"

// Notes on behaviour
// - four channels, each on its own byte lane of the 32-bit bus
// - only the upper eight of twelve result bits are latched
// - latch captures when converter status falls at end of conversion
// - converter status high while converting, low after twelfth bit
// - converter finishes within one microsecond of start
// - lane drives bus one cycle after its read strobe, for as long as the strobe was active
// - lane read strobes only during a processor read of the port
// - read completion held off while any converter is busy
// - delayed select backup completes a read if a converter fails
// - mux address auto-increments or is loaded directly
// - results offset binary, one means logic high
// - convert asserted on each read, conversion starts on its release
// - ready on all status low or 480 ns delayed select
// - each ready event without a port write increments the mux address by one
// - a port write loads mux address from data bits seven to zero
module qadc_port_ctrl
#(
    parameter CH     = `QADC_CH_COUNT,
    parameter LANE_W = `QADC_LANE_W,
    parameter CONV_W = `QADC_CONV_W,
    parameter MUX_W  = `QADC_MUX_W
)
(
    // clock and reset
    input  wire                CLK,
    input  wire                RESET_N,
    // processor port access
    input  wire                PORT_SEL,
    input  wire                PORT_RD,
    input  wire                PORT_WR,
    input  wire [`QADC_BUS_W-1:0] DATA_IN,
    // converter status and results
    input  wire [CH-1:0]       CONV_STATUS,
    input  wire [CH*CONV_W-1:0] CONV_DATA,
    // converter start
    output reg                 CONVERT_N,
    // data bus drive
    output wire [`QADC_BUS_W-1:0] DATA_OUT,
    output wire [CH-1:0]       DATA_OE,
    output reg  [CH-1:0]       LANE_READ_STROBE_N,
    // processor handshake
    output reg                 READY_N,
    // analog mux address
    output reg  [MUX_W-1:0]    MUX_ADDRESS_LINES
);

    // ----------------------------------------------------------------
    // timing counts
    // ----------------------------------------------------------------
    localparam DLY_CYC = `QADC_READY_DELAY_NS / `QADC_CLK_PERIOD_NS;
    localparam LOW_CYC = (`QADC_CONV_LOW_NS + `QADC_CLK_PERIOD_NS - 1)
                         / `QADC_CLK_PERIOD_NS;
    localparam CNT_W   = 8;

    // states, one-hot
    localparam S_IDLE  = 3'b001;
    localparam S_CONV  = 3'b010;
    localparam S_DONE  = 3'b100;

    reg  [2:0]       state_q;
    reg  [2:0]       state_d;
    reg  [CNT_W-1:0] dly_q;
    reg  [CNT_W-1:0] low_q;
    reg              dsel_q;
    reg              pend_q;
    reg              ready_n_d;
    reg  [CH-1:0]    strobe_n_d;
    wire [CH-1:0]    busy;
    wire             port_read;
    wire             all_idle;
    wire             stretch;
    wire             status_ok;
    wire             in_conv;
    wire             ready_ev;
    wire             mux_load;
    wire             mux_step;

    assign port_read = PORT_SEL & PORT_RD;
    assign all_idle  = ~|busy;
    assign in_conv   = (state_q == S_CONV);

    // ----------------------------------------------------------------
    // channels
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < CH; g = g + 1)
        begin : g_lane
            qadc_lane #(
                .CONV_W (CONV_W),
                .LANE_W (LANE_W)
            ) u_lane (
                .clk              (CLK),
                .reset_n          (RESET_N),
                .conv_data        (CONV_DATA[g*CONV_W +: CONV_W]),
                .conv_status      (CONV_STATUS[g]),
                .lane_read_strobe (~LANE_READ_STROBE_N[g]),
                .lane_data_q      (DATA_OUT[g*LANE_W +: LANE_W]),
                .lane_oe_q        (DATA_OE[g]),
                .busy_q           (busy[g])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // convert strobe and delayed select
    // ----------------------------------------------------------------
    // the convert low time is stretched so a short read still meets
    // the converter's minimum pulse width
    always @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            CONVERT_N <= 1'b1;
            low_q     <= {CNT_W{1'b0}};
            dly_q     <= {CNT_W{1'b0}};
            dsel_q    <= 1'b0;
        end
        else
        begin
            if (port_read)
            begin
                CONVERT_N <= 1'b0;
                low_q     <= LOW_CYC[CNT_W-1:0];
            end
            else if (low_q > {CNT_W{1'b0}})
                low_q <= low_q - 1'b1;
            else
                CONVERT_N <= 1'b1;
            // select delayed by the fixed line time
            if (!PORT_SEL)
            begin
                dly_q  <= {CNT_W{1'b0}};
                dsel_q <= 1'b0;
            end
            else if (dly_q < DLY_CYC[CNT_W-1:0])
                dly_q <= dly_q + 1'b1;
            else
                dsel_q <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // conversion pending
    // ----------------------------------------------------------------
    // status is low both before a conversion starts and after it ends;
    // while the convert stretch of an earlier read runs, low status is
    // stale and may not complete an access until a converter has been
    // seen busy. a failed converter stays busy instead, and the delayed
    // select then completes the access
    assign stretch = ~CONVERT_N & ~port_read;

    always @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            pend_q <= 1'b0;
        else if (stretch)
            pend_q <= 1'b1;
        else if (|busy)
            pend_q <= 1'b0;
    end

    // ----------------------------------------------------------------
    // read handshake
    // ----------------------------------------------------------------
    // ready is held once per access; the backup fires even if a
    // converter never drops its status
    assign status_ok = all_idle & ~pend_q;
    assign ready_ev  = in_conv & PORT_SEL &
                       (status_ok | dsel_q);

    // next state and next handshake levels
    always @*
    begin
        state_d    = state_q;
        ready_n_d  = READY_N;
        strobe_n_d = LANE_READ_STROBE_N;
        case (state_q)
            S_IDLE:
            begin
                ready_n_d  = 1'b1;
                strobe_n_d = {CH{1'b1}};
                if (PORT_SEL)
                    state_d = S_CONV;
            end
            S_CONV:
            begin
                if (!PORT_SEL)
                    state_d = S_IDLE;
                else if (ready_ev)
                begin
                    ready_n_d = 1'b0;
                    if (port_read)
                        strobe_n_d = {CH{1'b0}};
                    state_d = S_DONE;
                end
            end
            S_DONE:
            begin
                if (!PORT_SEL)
                begin
                    ready_n_d  = 1'b1;
                    strobe_n_d = {CH{1'b1}};
                    state_d    = S_IDLE;
                end
            end
            default:
            begin
                ready_n_d  = 1'b1;
                strobe_n_d = {CH{1'b1}};
                state_d    = S_IDLE;
            end
        endcase
    end

    // handshake outputs come straight from these flops
    always @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            state_q            <= S_IDLE;
            READY_N            <= 1'b1;
            LANE_READ_STROBE_N <= {CH{1'b1}};
        end
        else
        begin
            state_q            <= state_d;
            READY_N            <= ready_n_d;
            LANE_READ_STROBE_N <= strobe_n_d;
        end
    end

    // ----------------------------------------------------------------
    // mux address counter
    // ----------------------------------------------------------------
    // a write on the ready event wins over the increment
    assign mux_load = ready_ev & PORT_WR;
    assign mux_step = ready_ev & ~PORT_WR;

    always @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            MUX_ADDRESS_LINES <= `QADC_MUX_RESET;
        else if (mux_load)
            MUX_ADDRESS_LINES <= DATA_IN[MUX_W-1:0];
        else if (mux_step)
            MUX_ADDRESS_LINES <= MUX_ADDRESS_LINES + 1'b1;
    end

endmodule // qadc_port_ctrl

`default_nettype wire

// File: verification/qadc_port_ctrl_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module qadc_port_ctrl_asserts
(
    // clock and reset
    input wire logic        CLK,
    input wire logic        RESET_N,
    // processor access
    input wire logic        PORT_SEL,
    input wire logic        PORT_RD,
    input wire logic        PORT_WR,
    input wire logic [31:0] DATA_IN,
    // converters
    input wire logic [3:0]  CONV_STATUS,
    input wire logic [47:0] CONV_DATA,
    input wire logic        CONVERT_N,
    // bus and mux
    input wire logic [31:0] DATA_OUT,
    input wire logic [3:0]  DATA_OE,
    input wire logic [3:0]  LANE_READ_STROBE_N,
    input wire logic        READY_N,
    input wire logic [7:0]  MUX_ADDRESS_LINES
);
// ---
// port checks
// ---
default clocking @(posedge CLK); endclocking
default disable iff (!RESET_N);
chk_strobe_on_read: assert property (
    LANE_READ_STROBE_N != 4'hf |-> $past(PORT_SEL && PORT_RD))
    else $error("strobe outside read");
chk_oe_after_strobe: assert property (
    DATA_OE == ~$past(LANE_READ_STROBE_N))
    else $error("lane drive not one cycle after strobe");
chk_convert_on_read: assert property (
    $fell(CONVERT_N) |-> $past(PORT_SEL && PORT_RD))
    else $error("convert without read");
chk_convert_width: assert property (
    $fell(CONVERT_N) |-> !CONVERT_N [*7])
    else $error("convert low too short");
chk_lane_capture: assert property (
    $fell(CONV_STATUS[0]) |-> ##[1:3] DATA_OUT[7:0] == CONV_DATA[11:4])
    else $error("lane zero capture wrong");
chk_ready_bound: assert property (
    $rose(PORT_SEL) |-> ##[1:64] !READY_N)
    else $error("ready late");
chk_ready_busy: assert property (
    ($rose(PORT_SEL) && |CONV_STATUS) ##1 (|CONV_STATUS) [*7] |-> READY_N)
    else $error("ready while converting");
chk_write_no_strobe: assert property (
    PORT_SEL && PORT_WR |=> LANE_READ_STROBE_N == 4'hf)
    else $error("strobe on write");
cov_read_ready: cover property ($fell(READY_N) && PORT_RD);
cov_backup_ready: cover property ($fell(READY_N) && |CONV_STATUS);
cov_port_write: cover property (PORT_SEL && PORT_WR);
cov_lane_done: cover property ($fell(CONV_STATUS[3]));
endmodule // qadc_port_ctrl_asserts

bind qadc_port_ctrl qadc_port_ctrl_asserts i_qadc_port_ctrl_asserts
(
    .CLK, .RESET_N, .PORT_SEL, .PORT_RD, .PORT_WR, .DATA_IN, .CONV_STATUS,
    .CONV_DATA, .CONVERT_N, .DATA_OUT, .DATA_OE, .LANE_READ_STROBE_N,
    .READY_N, .MUX_ADDRESS_LINES
);
`default_nettype wire

// File: verification/qadc_conv_model.sv
`timescale 1ns/1ns
`default_nettype none
module qadc_conv_model
(
    // start and result setup
    input  wire logic        clk,
    input  wire logic        convert_n,
    input  wire logic [47:0] val,
    input  wire logic [3:0]  stuck,
    // converter outputs
    output var  logic [3:0]  status,
    output var  logic [47:0] data
);
int low = 0;
int cnt = 0;
initial
begin
    status = 4'h0;
    data = 48'h0;
end
// 12 cycles is 96 ns, well under the microsecond limit
always @(posedge clk)
begin
    low <= convert_n ? 0 : low + 1;
    if (convert_n && low >= 7)
    begin
        cnt <= 1;
        status <= 4'hf;
        data <= ~val;
    end
    else if (cnt > 0)
        cnt <= cnt + 1;
    if (cnt == 12)
    begin
        status <= stuck;
        data <= val;
    end
    // result held only briefly, so a late capture shows up
    if (cnt == 16)
        data <= ~val;
end
endmodule // qadc_conv_model
`default_nettype wire

// File: verification/tb_quad_adc_port_control.sv
`timescale 1ns/1ns
`default_nettype none
module tb_quad_adc_port_control;
logic        clk = 0;
logic        rst_n = 0;
logic        sel = 0;
logic        rd = 0;
logic        wr = 0;
logic [31:0] din = 0;
logic [47:0] val = 0;
logic [3:0]  stuck = 0;
logic        hung = 0;
logic [31:0] exp_lanes = 0;
logic [7:0]  exp_mux = 0;
wire  [3:0]  st, oe, sn;
wire  [47:0] cd;
wire  [31:0] dout;
wire  [7:0]  mux;
wire         cn, rdy_n;
int          fail_count = 0;
int          total_checks = 0;
int          cyc = 0;
int          seed = 12;
int          i;
always #4 clk = ~clk;
qadc_port_ctrl i_qadc_port_ctrl (.CLK(clk), .RESET_N(rst_n), .PORT_SEL(sel),
    .PORT_RD(rd), .PORT_WR(wr), .DATA_IN(din), .CONV_STATUS(st),
    .CONV_DATA(cd), .CONVERT_N(cn), .DATA_OUT(dout), .DATA_OE(oe),
    .LANE_READ_STROBE_N(sn), .READY_N(rdy_n), .MUX_ADDRESS_LINES(mux));
qadc_conv_model i_qadc_conv_model (.clk(clk), .convert_n(cn), .val(val),
    .stuck(stuck), .status(st), .data(cd));
task complete_run;
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
        $display("STATUS OK");
    else
        $display("STATUS NOT OK");
    $finish;
endtask
task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
        fail_count++;
        $display("Error %s expected %h seen %h", nm, exp, seen);
    end
endtask
// ---
// one port access, select held until ready
// ---
task access(input logic w, input logic [7:0] d);
    int t;
    t = 0;
    sel <= 1;
    rd <= !w;
    wr <= w;
    din <= {24'($random(seed)), d};
    while (rdy_n !== 1'b0 && t < 80)
    begin
        @(posedge clk);
        #1;
        t++;
    end
    // idle converters answer at once, a stuck one only via the backup
    chk("wait", hung ? (t >= 60 && t <= 64) : (t <= 3), 1);
    @(posedge clk);
    #1;
    chk("strobe", {sn, oe}, w ? 8'hf0 : 8'h0f);
    chk("lanes", dout, exp_lanes);
    exp_mux = w ? d : exp_mux + 8'h01;
    chk("mux", mux, exp_mux);
    sel <= 0;
    rd <= 0;
    wr <= 0;
    // conversion starts only once the read lets go of convert
    repeat (30) @(posedge clk);
    #1;
    if (!w)
    begin
        hung = |stuck;
        for (int k = 0; k < 4; k++)
            if (!stuck[k])
                exp_lanes[8*k+:8] = val[12*k+4+:8];
    end
endtask
initial
begin
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1;
    chk("idle", {cn, rdy_n, sn, oe, mux}, 18'h3f000);
    for (i = 0; i < 8; i++)
    begin
        val = 48'({$random(seed), $random(seed)});
        stuck = (i == 3) ? 4'h5 : 4'h0;
        access(i == 5 || i == 6, i == 6 ? 8'hff : 8'($random(seed)));
    end
    complete_run;
end
always @(posedge clk)
begin
    cyc++;
    if (cyc > 5000)
    begin
        fail_count++;
        complete_run;
    end
end
endmodule // tb_quad_adc_port_control
`default_nettype wire
